// ---- hdl/dma_pkg.sv ----
// constants, register map and state codes for the single-channel dma mover
package dma_pkg;

    localparam int unsigned DATA_W  = 16;
    localparam int unsigned RAM_W   = 16;
    localparam int unsigned SFR_W   = 8;
    localparam int unsigned CNT_W   = 16;
    localparam int unsigned TRIG_W  = 4;
    localparam int unsigned NUM_EVT = 11;
    localparam int unsigned PADDR_W = 8;
    localparam int unsigned PDATA_W = 32;

    localparam logic [PADDR_W-1:0] OFS_CTRL = 8'h00;
    localparam logic [PADDR_W-1:0] OFS_MASK = 8'h04;
    localparam logic [PADDR_W-1:0] OFS_MODE = 8'h08;
    localparam logic [PADDR_W-1:0] OFS_SFRA = 8'h0C;
    localparam logic [PADDR_W-1:0] OFS_RAMA = 8'h10;
    localparam logic [PADDR_W-1:0] OFS_CNT  = 8'h14;
    localparam logic [PADDR_W-1:0] OFS_FLAG = 8'h18;

    localparam int unsigned CTRL_EN_BIT  = 7;
    localparam int unsigned CTRL_ACT_BIT = 0;
    localparam int unsigned MASK_BIT     = 6;
    localparam int unsigned MODE_SW_BIT  = 7;
    localparam int unsigned MODE_DIR_BIT = 6;
    localparam int unsigned MODE_SZ_BIT  = 5;
    localparam int unsigned MODE_HLD_BIT = 4;
    localparam int unsigned FLAG_BIT     = 0;

    localparam logic [TRIG_W-1:0] TRIG_NONE = 4'h0;
    localparam logic [TRIG_W-1:0] TRIG_AD   = 4'h1;

    localparam logic              MASK_RST  = 1'b1;
    localparam logic [CNT_W-1:0]  CNT_ONE   = 16'h0001;
    localparam logic [CNT_W-1:0]  CNT_ZERO  = 16'h0000;
    localparam logic [RAM_W-1:0]  STEP_BYTE = 16'h0001;
    localparam logic [RAM_W-1:0]  STEP_WORD = 16'h0002;
    localparam logic [DATA_W-1:0] BYTE_MASK = 16'h00FF;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_READ  = 2'b01,
        ST_WAIT  = 2'b10,
        ST_WRITE = 2'b11
    } eng_state_t;

endpackage

// ---- hdl/dma_trigger_select.sv ----
// start-source selector: picks one peripheral event by its 4-bit code
`timescale 1ns/1ps
module dma_trigger_select #(
    parameter int unsigned NUM_EVT = dma_pkg::NUM_EVT
) (
    input  wire logic                        clk,
    input  wire logic                        reset,
    input  wire logic [dma_pkg::TRIG_W-1:0]  code,
    input  wire logic [NUM_EVT-1:0]          events,
    output logic                             hit
);
    import dma_pkg::*;

    logic [NUM_EVT-1:0] match;

    if (NUM_EVT < 1 || NUM_EVT >= (1 << TRIG_W)) begin : g_chk
        $error("NUM_EVT does not fit the trigger code");
    end

    // code i+1 selects event i; zero and codes past the list select nothing
    for (genvar i = 0; i < NUM_EVT; i++) begin : g_sel
        assign match[i] = (code == TRIG_W'(i + 1)) && events[i];
    end

    always_comb begin
        hit = |match;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    chk_no_source_code: assert property ((code == TRIG_NONE) |-> !hit)
        else $error("trigger hit with source code zero");
    chk_prohibited_code: assert property ((code > TRIG_W'(NUM_EVT)) |-> !hit)
        else $error("trigger hit with prohibited source code");
    chk_ad_source: assert property ((code == TRIG_AD) |-> (hit == events[0]))
        else $error("conversion event not routed for code one");

endmodule

// ---- hdl/dma_channel_sfr_ram_mover.sv ----
// single dma channel moving 8/16-bit units between one sfr and on-chip ram, apb registers
//
// Added by the designer: the APB register port and the register addresses.
`timescale 1ns/1ps
module dma_channel_sfr_ram_mover (
    input  wire logic                         clk,
    input  wire logic                         reset,
    input  wire logic                         psel,
    input  wire logic                         penable,
    input  wire logic                         pwrite,
    input  wire logic [dma_pkg::PADDR_W-1:0]  paddr,
    input  wire logic [dma_pkg::PDATA_W-1:0]  pwdata,
    output logic      [dma_pkg::PDATA_W-1:0]  prdata,
    output logic                              pready,
    output logic                              pslverr,
    input  wire logic                         conversion_done_event,
    input  wire logic                         timer_ch0_event,
    input  wire logic                         timer_ch1_event,
    input  wire logic                         timer_ch2_event,
    input  wire logic                         timer_ch3_event,
    input  wire logic                         serial0_tx_event,
    input  wire logic                         serial0_rx_event,
    input  wire logic                         serial1_tx_event,
    input  wire logic                         serial1_rx_event,
    input  wire logic                         serial2_tx_event,
    input  wire logic                         serial2_rx_event,
    output logic      [dma_pkg::SFR_W-1:0]    sfr_addr,
    output logic                              sfr_re,
    output logic                              sfr_we,
    output logic                              sfr_wide,
    output logic      [dma_pkg::DATA_W-1:0]   sfr_wdata,
    input  wire logic [dma_pkg::DATA_W-1:0]   sfr_rdata,
    output logic      [dma_pkg::RAM_W-1:0]    ram_addr,
    output logic                              ram_re,
    output logic                              ram_we,
    output logic                              ram_wide,
    output logic      [dma_pkg::DATA_W-1:0]   ram_wdata,
    input  wire logic [dma_pkg::DATA_W-1:0]   ram_rdata,
    output logic                              transfer_end_irq
);
    import dma_pkg::*;

    // bus slave state
    logic [PDATA_W-1:0] prdata_ff, nxt_prdata;
    logic               pready_ff, nxt_pready;
    logic               pslverr_ff, nxt_pslverr;

    // configuration and channel state
    logic               enable_ff, nxt_enable;
    logic               active_ff, nxt_active;
    logic               mask_ff, nxt_mask;
    logic               dir_ff, nxt_dir;
    logic               size_ff, nxt_size;
    logic               hold_ff, nxt_hold;
    logic [TRIG_W-1:0]  trig_ff, nxt_trig;
    logic [SFR_W-1:0]   sfra_ff, nxt_sfra;
    logic [RAM_W-1:0]   rama_ff, nxt_rama;
    logic [CNT_W-1:0]   cnt_ff, nxt_cnt;
    logic               flag_ff, nxt_flag;
    logic               pend_ff, nxt_pend;
    logic               irq_ff, nxt_irq;

    // transfer engine
    eng_state_t         state_ff, nxt_state;
    logic [DATA_W-1:0]  data_ff, nxt_data;
    logic               sfr_re_ff, nxt_sfr_re;
    logic               sfr_we_ff, nxt_sfr_we;
    logic               ram_re_ff, nxt_ram_re;
    logic               ram_we_ff, nxt_ram_we;

    logic                trig_hit;
    logic [NUM_EVT-1:0]  events;
    logic                acc;
    logic                wr;
    logic                mapped;
    logic                start;
    logic                sw_trig;
    logic [RAM_W-1:0]    step;
    logic [DATA_W-1:0]   rd_word;

    assign events = {serial2_rx_event, serial2_tx_event, serial1_rx_event, serial1_tx_event,
                     serial0_rx_event, serial0_tx_event, timer_ch3_event, timer_ch2_event,
                     timer_ch1_event, timer_ch0_event, conversion_done_event};

    dma_trigger_select #(
        .NUM_EVT (NUM_EVT)
    ) u_trig (
        .clk    (clk),
        .reset  (reset),
        .code   (trig_ff),
        .events (events),
        .hit    (trig_hit)
    );

    // a write lands only at the edge where pready is seen high
    assign acc     = psel && penable && pready_ff;
    assign wr      = acc && pwrite;
    assign mapped  = (paddr == OFS_CTRL) || (paddr == OFS_MASK) || (paddr == OFS_MODE) ||
                     (paddr == OFS_SFRA) || (paddr == OFS_RAMA) || (paddr == OFS_CNT) ||
                     (paddr == OFS_FLAG);
    assign sw_trig = wr && enable_ff && (paddr == OFS_MODE) && pwdata[MODE_SW_BIT];
    assign start   = (state_ff == ST_IDLE) && pend_ff && !hold_ff && active_ff &&
                     enable_ff && (cnt_ff != CNT_ZERO);
    assign step    = size_ff ? STEP_WORD : STEP_BYTE;
    assign rd_word = dir_ff ? ram_rdata : sfr_rdata;

    always_comb begin
        nxt_pready  = psel && penable && !pready_ff;
        nxt_pslverr = psel && penable && !pready_ff && !mapped;
        nxt_prdata  = '0;
        if (psel && penable && !pready_ff && !pwrite) begin
            case (paddr)
                OFS_CTRL: begin
                    nxt_prdata[CTRL_EN_BIT]  = enable_ff;
                    nxt_prdata[CTRL_ACT_BIT] = active_ff;
                end
                OFS_MASK: nxt_prdata[MASK_BIT] = mask_ff;
                OFS_MODE: begin
                    nxt_prdata[MODE_DIR_BIT]   = dir_ff;
                    nxt_prdata[MODE_SZ_BIT]    = size_ff;
                    nxt_prdata[MODE_HLD_BIT]   = hold_ff;
                    nxt_prdata[TRIG_W-1:0]     = trig_ff;
                end
                OFS_SFRA: nxt_prdata[SFR_W-1:0] = sfra_ff;
                OFS_RAMA: nxt_prdata[RAM_W-1:0] = rama_ff;
                OFS_CNT:  nxt_prdata[CNT_W-1:0] = cnt_ff;
                OFS_FLAG: nxt_prdata[FLAG_BIT]  = flag_ff;
                default:  nxt_prdata = '0;
            endcase
        end
    end

    always_comb begin
        nxt_enable = enable_ff;
        nxt_active = active_ff;
        nxt_mask   = mask_ff;
        nxt_dir    = dir_ff;
        nxt_size   = size_ff;
        nxt_hold   = hold_ff;
        nxt_trig   = trig_ff;
        nxt_sfra   = sfra_ff;
        nxt_rama   = rama_ff;
        nxt_cnt    = cnt_ff;
        nxt_flag   = flag_ff;
        nxt_pend   = pend_ff;
        nxt_state  = state_ff;
        nxt_data   = data_ff;
        nxt_sfr_re = 1'b0;
        nxt_sfr_we = 1'b0;
        nxt_ram_re = 1'b0;
        nxt_ram_we = 1'b0;
        if (wr && paddr == OFS_CTRL) begin
            nxt_enable = pwdata[CTRL_EN_BIT];
            nxt_active = pwdata[CTRL_EN_BIT] && pwdata[CTRL_ACT_BIT];
        end
        if (wr && paddr == OFS_MASK) begin
            nxt_mask = pwdata[MASK_BIT];
        end
        if (wr && paddr == OFS_FLAG && !pwdata[FLAG_BIT]) begin
            nxt_flag = 1'b0;
        end
        // setup registers only take writes while the channel is enabled
        if (wr && enable_ff) begin
            case (paddr)
                OFS_MODE: begin
                    nxt_dir  = pwdata[MODE_DIR_BIT];
                    nxt_size = pwdata[MODE_SZ_BIT];
                    nxt_hold = pwdata[MODE_HLD_BIT];
                    nxt_trig = pwdata[TRIG_W-1:0];
                end
                OFS_SFRA: nxt_sfra = pwdata[SFR_W-1:0];
                OFS_RAMA: nxt_rama = pwdata[RAM_W-1:0];
                OFS_CNT:  nxt_cnt  = pwdata[CNT_W-1:0];
                default:  nxt_cnt  = nxt_cnt;
            endcase
        end
        if (start) begin
            nxt_pend = 1'b0;
        end
        // a request arriving as the previous one is consumed stays pending
        if (enable_ff && (trig_hit || sw_trig)) begin
            nxt_pend = 1'b1;
        end
        case (state_ff)
            ST_IDLE: begin
                if (start) begin
                    nxt_state  = ST_READ;
                    nxt_sfr_re = !dir_ff;
                    nxt_ram_re = dir_ff;
                end
            end
            ST_READ: begin
                nxt_state = ST_WAIT;
            end
            ST_WAIT: begin
                nxt_data   = size_ff ? rd_word : (rd_word & BYTE_MASK);
                nxt_state  = ST_WRITE;
                nxt_ram_we = !dir_ff;
                nxt_sfr_we = dir_ff;
            end
            ST_WRITE: begin
                nxt_state = ST_IDLE;
                nxt_rama  = RAM_W'(rama_ff + step);
                nxt_cnt   = CNT_W'(cnt_ff - CNT_ONE);
                if (cnt_ff == CNT_ONE) begin
                    nxt_active = 1'b0;
                    nxt_flag   = 1'b1;
                end
            end
            default: nxt_state = ST_IDLE;
        endcase
        // disabled channel: engine held, strobes dropped
        if (!nxt_enable) begin
            nxt_state  = ST_IDLE;
            nxt_pend   = 1'b0;
            nxt_active = 1'b0;
            nxt_sfr_re = 1'b0;
            nxt_sfr_we = 1'b0;
            nxt_ram_re = 1'b0;
            nxt_ram_we = 1'b0;
        end
        nxt_irq = nxt_flag && !nxt_mask;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            prdata_ff  <= '0;
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            enable_ff  <= 1'b0;
            active_ff  <= 1'b0;
            mask_ff    <= MASK_RST;
            dir_ff     <= 1'b0;
            size_ff    <= 1'b0;
            hold_ff    <= 1'b0;
            trig_ff    <= TRIG_NONE;
            sfra_ff    <= '0;
            rama_ff    <= '0;
            cnt_ff     <= CNT_ZERO;
            flag_ff    <= 1'b0;
            pend_ff    <= 1'b0;
            irq_ff     <= 1'b0;
            state_ff   <= ST_IDLE;
            data_ff    <= '0;
            sfr_re_ff  <= 1'b0;
            sfr_we_ff  <= 1'b0;
            ram_re_ff  <= 1'b0;
            ram_we_ff  <= 1'b0;
        end else begin
            prdata_ff  <= nxt_prdata;
            pready_ff  <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
            enable_ff  <= nxt_enable;
            active_ff  <= nxt_active;
            mask_ff    <= nxt_mask;
            dir_ff     <= nxt_dir;
            size_ff    <= nxt_size;
            hold_ff    <= nxt_hold;
            trig_ff    <= nxt_trig;
            sfra_ff    <= nxt_sfra;
            rama_ff    <= nxt_rama;
            cnt_ff     <= nxt_cnt;
            flag_ff    <= nxt_flag;
            pend_ff    <= nxt_pend;
            irq_ff     <= nxt_irq;
            state_ff   <= nxt_state;
            data_ff    <= nxt_data;
            sfr_re_ff  <= nxt_sfr_re;
            sfr_we_ff  <= nxt_sfr_we;
            ram_re_ff  <= nxt_ram_re;
            ram_we_ff  <= nxt_ram_we;
        end
    end

    assign prdata           = prdata_ff;
    assign pready           = pready_ff;
    assign pslverr          = pslverr_ff;
    assign sfr_addr         = sfra_ff;
    assign sfr_re           = sfr_re_ff;
    assign sfr_we           = sfr_we_ff;
    assign sfr_wide         = size_ff;
    assign sfr_wdata        = data_ff;
    assign ram_addr         = rama_ff;
    assign ram_re           = ram_re_ff;
    assign ram_we           = ram_we_ff;
    assign ram_wide         = size_ff;
    assign ram_wdata        = data_ff;
    assign transfer_end_irq = irq_ff;

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    chk_disabled_idle: assert property (!enable_ff |-> (state_ff == ST_IDLE) &&
                                        !sfr_re_ff && !ram_re_ff && !sfr_we_ff && !ram_we_ff)
        else $error("disabled channel is moving data");
    chk_setup_refused: assert property ((wr && !enable_ff && paddr == OFS_CNT)
                                        |=> $stable(cnt_ff))
        else $error("setup write taken while disabled");
    chk_setup_taken: assert property ((wr && enable_ff && paddr == OFS_CNT &&
                                       state_ff != ST_WRITE)
                                      |=> cnt_ff == $past(pwdata[CNT_W-1:0]))
        else $error("count write lost while enabled");
    chk_end_clears: assert property (state_ff == ST_WRITE && cnt_ff == CNT_ONE &&
                                     enable_ff && !wr |=> !active_ff && flag_ff && cnt_ff == '0)
        else $error("sequence end did not clear active and raise request");
    chk_irq_mask: assert property (irq_ff == (flag_ff && !mask_ff))
        else $error("end interrupt does not follow flag and mask");
    chk_dir_path: assert property ((state_ff == ST_IDLE && start) |=>
                                   (sfr_re_ff == !dir_ff) ##2 (ram_we_ff == !dir_ff))
        else $error("transfer direction wrong");
    chk_byte_unit: assert property ((ram_we_ff || sfr_we_ff) && !size_ff
                                    |-> (data_ff & ~BYTE_MASK) == '0)
        else $error("byte transfer carried upper bits");
    chk_prompt_start: assert property (start |=> state_ff == ST_READ || !enable_ff)
        else $error("unheld request not served at once");
    chk_hold_defers: assert property (state_ff == ST_IDLE && hold_ff
                                      |=> state_ff != ST_READ)
        else $error("held request was executed");
    chk_ram_advance: assert property ((state_ff == ST_WRITE && enable_ff && !wr) |=>
                                      rama_ff == RAM_W'($past(rama_ff) + $past(step)))
        else $error("ram address did not step by unit size");

    cov_sequence_end: cover property (state_ff == ST_WRITE && cnt_ff == CNT_ONE);
    cov_held_request: cover property (pend_ff && hold_ff ##1 !hold_ff ##1 state_ff == ST_READ);
    cov_sw_trigger:   cover property (sw_trig ##[1:3] state_ff == ST_READ);
    cov_ram_to_sfr:   cover property (sfr_we_ff && size_ff);

endmodule

// ---- test/sfr_ram_model.sv ----
// far-side model: peripheral registers and on-chip ram with synchronous reads
`timescale 1ns/1ps
module sfr_ram_model (
    input  wire logic        clk,
    input  wire logic [7:0]  sfr_addr,
    input  wire logic        sfr_re,
    input  wire logic        sfr_we,
    input  wire logic        sfr_wide,
    input  wire logic [15:0] sfr_wdata,
    output logic      [15:0] sfr_rdata,
    input  wire logic [15:0] ram_addr,
    input  wire logic        ram_re,
    input  wire logic        ram_we,
    input  wire logic        ram_wide,
    input  wire logic [15:0] ram_wdata,
    output logic      [15:0] ram_rdata
);
    logic [15:0] sfr_mem [256];
    logic [7:0]  ram_mem [65536];
    initial sfr_rdata = 16'h0000;
    initial ram_rdata = 16'h0000;
    // no read strobe: data lines toggle so stale values never pass
    always @(posedge clk) begin
        if (sfr_we)
            sfr_mem[sfr_addr] <= sfr_wide ? sfr_wdata : {sfr_mem[sfr_addr][15:8], sfr_wdata[7:0]};
        sfr_rdata <= sfr_re ? sfr_mem[sfr_addr] : ~sfr_rdata;
        if (ram_we)
            ram_mem[ram_addr] <= ram_wdata[7:0];
        if (ram_we && ram_wide)
            ram_mem[ram_addr + 16'h0001] <= ram_wdata[15:8];
        ram_rdata <= ram_re ? {ram_mem[ram_addr + 16'h0001], ram_mem[ram_addr]} : ~ram_rdata;
    end
endmodule

// ---- test/tb_top.sv ----
// testbench: apb register access and event-started transfers
`timescale 1ns/1ps
module tb_top;
    import dma_pkg::*;
    logic        clk, reset, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr, sfr_addr;
    logic [31:0] pwdata, prdata, rd_q;
    logic        sfr_re, sfr_we, sfr_wide, ram_re, ram_we, ram_wide;
    logic [15:0] sfr_wdata, sfr_rdata, ram_addr, ram_wdata, ram_rdata;
    logic        transfer_end_irq, err_q;
    logic [10:0] evt;
    int          n_mismatch = 0;
    int          num_checks = 0;
    int          cyc = 0;

    dma_channel_sfr_ram_mover dut_u (
        .conversion_done_event (evt[0]),
        .timer_ch0_event       (evt[1]),
        .timer_ch1_event       (evt[2]),
        .timer_ch2_event       (evt[3]),
        .timer_ch3_event       (evt[4]),
        .serial0_tx_event      (evt[5]),
        .serial0_rx_event      (evt[6]),
        .serial1_tx_event      (evt[7]),
        .serial1_rx_event      (evt[8]),
        .serial2_tx_event      (evt[9]),
        .serial2_rx_event      (evt[10]),
        .*
    );
    sfr_ram_model mdl_u (.*);

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            finish_test();
        end
    end

    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        num_checks++;
        if (got !== ex) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, ex, got);
        end
    endtask

    // request held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd_q  = prdata;
        err_q = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] ex);
        apb(1'b0, a, 32'h0);
        chk($sformatf("reg %h", a), ex, rd_q);
    endtask

    // one-cycle event pattern, then room for a whole transfer
    task automatic pulse(input logic [10:0] v);
        @(posedge clk);
        evt <= v;
        @(posedge clk);
        evt <= 11'h000;
        repeat (8) @(posedge clk);
    endtask

    task automatic finish_test;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial begin
        {reset, psel, penable, pwrite, paddr, pwdata, evt} = {1'b1, 54'h0};
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        rd(OFS_CTRL, 32'h0);
        rd(OFS_MASK, 32'h40);
        rd(8'h1C, 32'h0);
        chk("slverr", 32'h1, {31'h0, err_q});
        wr(OFS_SFRA, 32'h1E);
        rd(OFS_SFRA, 32'h0);
        wr(OFS_FLAG, 32'h0);
        wr(OFS_MASK, 32'h0);
        wr(OFS_CTRL, 32'h80);
        wr(OFS_SFRA, 32'h1E);
        rd(OFS_SFRA, 32'h1E);
        wr(OFS_RAMA, 32'h100);
        wr(OFS_CNT, 32'd40);
        rd(OFS_CNT, 32'd40);
        wr(OFS_CNT, 32'h2);
        wr(OFS_MODE, 32'h21);
        wr(OFS_CTRL, 32'h81);
        rd(OFS_CTRL, 32'h81);
        mdl_u.sfr_mem[8'h1E] = 16'hA5C3;
        pulse(11'h001);
        mdl_u.sfr_mem[8'h1E] = 16'h1234;
        rd(OFS_CNT, 32'h1);
        pulse(11'h001);
        chk("ram0", 32'hA5C3, {16'h0, mdl_u.ram_mem[16'h101], mdl_u.ram_mem[16'h100]});
        chk("ram1", 32'h1234, {16'h0, mdl_u.ram_mem[16'h103], mdl_u.ram_mem[16'h102]});
        rd(OFS_RAMA, 32'h104);
        rd(OFS_CTRL, 32'h80);
        rd(OFS_FLAG, 32'h1);
        chk("irq", 32'h1, {31'h0, transfer_end_irq});
        wr(OFS_MASK, 32'h40);
        rd(OFS_MASK, 32'h40);
        chk("irq", 32'h0, {31'h0, transfer_end_irq});
        wr(OFS_FLAG, 32'h0);
        wr(OFS_RAMA, 32'h200);
        for (int c = 1; c <= 11; c++) begin
            wr(OFS_MODE, c);
            wr(OFS_CNT, 32'h1);
            wr(OFS_CTRL, 32'h81);
            pulse(11'h001 << (c % 11));
            rd(OFS_CNT, 32'h1);
            pulse(11'h001 << (c - 1));
            rd(OFS_CNT, 32'h0);
        end
        rd(OFS_RAMA, 32'h20B);
        wr(OFS_CNT, 32'h1);
        wr(OFS_CTRL, 32'h81);
        for (int c = 12; c <= 16; c++) begin
            wr(OFS_MODE, c % 16);
            pulse(11'h7FF);
            rd(OFS_CNT, 32'h1);
        end
        wr(OFS_MODE, 32'h80);
        pulse(11'h000);
        rd(OFS_CNT, 32'h0);
        mdl_u.ram_mem[16'h300] = 8'h5A;
        mdl_u.sfr_mem[8'h30] = 16'hFFFF;
        wr(OFS_SFRA, 32'h30);
        wr(OFS_RAMA, 32'h300);
        wr(OFS_CNT, 32'h1);
        wr(OFS_CTRL, 32'h81);
        wr(OFS_MODE, 32'hD0);
        pulse(11'h000);
        rd(OFS_CNT, 32'h1);
        wr(OFS_MODE, 32'h40);
        pulse(11'h000);
        rd(OFS_CNT, 32'h0);
        chk("sfr", 32'hFF5A, {16'h0, mdl_u.sfr_mem[8'h30]});
        rd(OFS_RAMA, 32'h301);
        wr(OFS_MODE, 32'h01);
        wr(OFS_CNT, 32'h1);
        wr(OFS_CTRL, 32'h81);
        wr(OFS_CTRL, 32'h00);
        rd(OFS_CTRL, 32'h0);
        wr(OFS_CNT, 32'h5);
        pulse(11'h001);
        rd(OFS_CNT, 32'h1);
        finish_test();
    end
endmodule
